// *** verilog/bfu_defines.vh ***
/*
 * Constants of the bit and flag execution unit: register offsets,
 * field positions, reset values, opcodes, flag positions and cycle counts.
 * Assumes inclusion by bare name from the unit's design file and from both testbench files.
 */
`ifndef BFU_DEFINES_VH
`define BFU_DEFINES_VH

// Register byte offsets on the AXI4-Lite slave
`define BFU_OFS_CMD        8'h00
`define BFU_OFS_STATUS     8'h04
`define BFU_OFS_FLAGS      8'h08
`define BFU_OFS_STACK_TOP  8'h0c
`define BFU_OFS_WREG_BASE  8'h40
`define BFU_OFS_IO_BASE    8'h80

// Address bits [7:5] that select the working and I/O register banks
`define BFU_WREG_PAGE      3'h2
`define BFU_IO_PAGE        3'h4

// Command word fields
`define BFU_CMD_OP_MSB     4
`define BFU_CMD_OP_LSB     0
`define BFU_CMD_SEL_MSB    10
`define BFU_CMD_SEL_LSB    8
`define BFU_CMD_IDX_MSB    18
`define BFU_CMD_IDX_LSB    16

// Reset values
`define BFU_FLAGS_RST      8'h00
`define BFU_DATA_RST       8'h00

// Status flag positions inside the status_flags_register
`define BFU_FLAG_C         3'd0
`define BFU_FLAG_Z         3'd1
`define BFU_FLAG_N         3'd2
`define BFU_FLAG_V         3'd3
`define BFU_FLAG_S         3'd4
`define BFU_FLAG_H         3'd5
`define BFU_FLAG_T         3'd6
`define BFU_FLAG_I         3'd7

// Opcodes
`define BFU_OP_NOP         5'h00
`define BFU_OP_POP         5'h01
`define BFU_OP_IO_SET      5'h02
`define BFU_OP_IO_CLR      5'h03
`define BFU_OP_SLL         5'h04
`define BFU_OP_SRL         5'h05
`define BFU_OP_ROLC        5'h06
`define BFU_OP_RORC        5'h07
`define BFU_OP_SRA         5'h08
`define BFU_OP_SWAP        5'h09
`define BFU_OP_FSET        5'h0a
`define BFU_OP_FCLR        5'h0b
`define BFU_OP_TSTORE      5'h0c
`define BFU_OP_TLOAD       5'h0d
`define BFU_OP_VSET        5'h0e
`define BFU_OP_VCLR        5'h0f
`define BFU_OP_HSET        5'h10
`define BFU_OP_HCLR        5'h11
`define BFU_OP_SSET        5'h12
`define BFU_OP_SCLR        5'h13
`define BFU_OP_SLEEP       5'h14
`define BFU_OP_WD_RESTART  5'h15

// Execution lengths in clock cycles
`define BFU_CYC_ONE        2'd1
`define BFU_CYC_TWO        2'd2

// AXI responses
`define BFU_RESP_OKAY      2'b00
`define BFU_RESP_SLVERR    2'b10

`endif

// *** verilog/bfu_top.v ***
/*
 * Bit and flag execution unit with an AXI4-Lite register slave.
 * Software loads working, I/O and stack-top registers, writes a command,
 * and the unit executes it in one or two cycles, updating the flags.
 * Assumes one clock clk_sys (100 MHz) and a synchronous active-low nrst.
 */
// Register access over AXI4-Lite and the address map are this design's own decisions.
`timescale 1ns/100ps
`include "bfu_defines.vh"

module bfu_top #(
	parameter WREG_NUM = 8,                // Working registers
	parameter IO_NUM   = 8                 // I/O registers
) (
	input  wire        clk_sys,
	input  wire        nrst,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	output reg         busy,
	output reg  [7:0]  flags_out,
	output reg         sleep_req,
	output reg         watchdog_restart_op
);

	// Architectural state
	reg  [7:0]  wreg_reg [0:WREG_NUM-1];   // Working registers
	reg  [7:0]  io_reg   [0:IO_NUM-1];     // I/O registers
	reg  [7:0]  flags_reg;                 // status_flags_register
	reg  [7:0]  stack_top_reg;             // Value the next pop returns

	// Command in flight
	reg  [4:0]  op_reg;                    // Latched opcode
	reg  [2:0]  sel_reg;                   // Bit or flag select
	reg  [2:0]  idx_reg;                   // Register index
	reg  [1:0]  cnt_reg;                   // Cycles left in execution

	// Write channel holding state
	reg  [7:0]  aw_addr_reg;               // Captured write address
	reg         aw_have_reg;               // Address taken, awaiting data
	reg  [31:0] w_data_reg;                // Captured write data
	reg  [3:0]  w_strb_reg;                // Captured byte strobes
	reg         w_have_reg;                // Data taken, awaiting address

	// Combinational helpers
	reg  [7:0]  res_next;                  // Shift/rotate result
	reg         cout_next;                 // Carry out of shift/rotate
	reg         wr_ok;                     // Write address is mapped
	reg         rd_ok;                     // Read address is mapped
	reg  [31:0] rd_data;                   // Read mux output
	wire [7:0]  wsel   = wreg_reg[idx_reg];
	wire        do_wr  = aw_have_reg && w_have_reg && !s_axi_bvalid;
	wire        strb0  = w_strb_reg[0];
	wire [7:0]  wbyte  = w_data_reg[7:0];
	wire        launch = do_wr && strb0 && (aw_addr_reg == `BFU_OFS_CMD) && !busy;
	wire        finish = busy && (cnt_reg == 2'd1);
	wire [2:0]  wa_idx = aw_addr_reg[4:2];
	wire [2:0]  ra_idx = s_axi_araddr[4:2];
	integer     i;

	// Shifter: result and carry out for every shift or rotate opcode
	always @* begin
		res_next  = wsel;
		cout_next = flags_reg[`BFU_FLAG_C];
		case (op_reg)
			`BFU_OP_SLL: begin
				res_next  = {wsel[6:0], 1'b0};
				cout_next = wsel[7];
			end
			`BFU_OP_SRL: begin
				res_next  = {1'b0, wsel[7:1]};
				cout_next = wsel[0];
			end
			`BFU_OP_SRA: begin
				res_next  = {wsel[7], wsel[7:1]};
				cout_next = wsel[0];
			end
			`BFU_OP_ROLC: begin
				res_next  = {wsel[6:0], flags_reg[`BFU_FLAG_C]};
				cout_next = wsel[7];
			end
			`BFU_OP_RORC: begin
				res_next  = {flags_reg[`BFU_FLAG_C], wsel[7:1]};
				cout_next = wsel[0];
			end
			`BFU_OP_SWAP: begin
				res_next  = {wsel[3:0], wsel[7:4]};
			end
			default: begin
				res_next  = wsel;
			end
		endcase
	end

	// Address decode for writes: only word-aligned mapped addresses
	always @* begin
		wr_ok = 1'b0;
		if (aw_addr_reg[1:0] != 2'b00) begin
			wr_ok = 1'b0;
		end else if (aw_addr_reg == `BFU_OFS_CMD || aw_addr_reg == `BFU_OFS_FLAGS ||
			aw_addr_reg == `BFU_OFS_STACK_TOP) begin
			wr_ok = 1'b1;
		end else if (aw_addr_reg[7:5] == `BFU_WREG_PAGE && wa_idx < WREG_NUM) begin
			wr_ok = 1'b1;
		end else if (aw_addr_reg[7:5] == `BFU_IO_PAGE && wa_idx < IO_NUM) begin
			wr_ok = 1'b1;
		end
	end

	// Address decode and data mux for reads; narrow registers sit low
	always @* begin
		rd_ok   = 1'b1;
		rd_data = 32'h0000_0000;
		if (s_axi_araddr[1:0] != 2'b00) begin
			rd_ok = 1'b0;
		end else if (s_axi_araddr == `BFU_OFS_CMD) begin
			rd_data = {13'h0000, idx_reg, 5'h00, sel_reg, 3'h0, op_reg};
		end else if (s_axi_araddr == `BFU_OFS_STATUS) begin
			rd_data = {16'h0000, flags_reg, 7'h00, busy};
		end else if (s_axi_araddr == `BFU_OFS_FLAGS) begin
			rd_data = {24'h000000, flags_reg};
		end else if (s_axi_araddr == `BFU_OFS_STACK_TOP) begin
			rd_data = {24'h000000, stack_top_reg};
		end else if (s_axi_araddr[7:5] == `BFU_WREG_PAGE && ra_idx < WREG_NUM) begin
			rd_data = {24'h000000, wreg_reg[ra_idx]};
		end else if (s_axi_araddr[7:5] == `BFU_IO_PAGE && ra_idx < IO_NUM) begin
			rd_data = {24'h000000, io_reg[ra_idx]};
		end else begin
			rd_ok = 1'b0;
		end
	end

	// Write channels: address and data taken independently, answer after both
	always @(posedge clk_sys) begin
		if (!nrst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `BFU_RESP_OKAY;
			aw_have_reg   <= 1'b0;
			w_have_reg    <= 1'b0;
			aw_addr_reg   <= 8'h00;
			w_data_reg    <= 32'h0000_0000;
			w_strb_reg    <= 4'h0;
		end else begin
			// Ready is a one-cycle pulse so each channel takes exactly one item
			s_axi_awready <= !aw_have_reg && !s_axi_awready && s_axi_awvalid;
			s_axi_wready  <= !w_have_reg && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr_reg <= s_axi_awaddr;
				aw_have_reg <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
				w_have_reg <= 1'b1;
			end
			if (do_wr) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? `BFU_RESP_OKAY : `BFU_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_have_reg  <= 1'b0;
				w_have_reg   <= 1'b0;
			end
		end
	end

	// Read channel: answer one cycle after the address is taken
	always @(posedge clk_sys) begin
		if (!nrst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `BFU_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_data;
				s_axi_rresp  <= rd_ok ? `BFU_RESP_OKAY : `BFU_RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Sequencer: a command runs one or two cycles; commands while busy are dropped
	always @(posedge clk_sys) begin
		if (!nrst) begin
			busy    <= 1'b0;
			cnt_reg <= 2'd0;
			op_reg  <= `BFU_OP_NOP;
			sel_reg <= 3'd0;
			idx_reg <= 3'd0;
		end else if (launch) begin
			busy    <= 1'b1;
			op_reg  <= w_data_reg[`BFU_CMD_OP_MSB:`BFU_CMD_OP_LSB];
			sel_reg <= w_data_reg[`BFU_CMD_SEL_MSB:`BFU_CMD_SEL_LSB];
			idx_reg <= w_data_reg[`BFU_CMD_IDX_MSB:`BFU_CMD_IDX_LSB];
			// Stack and I/O bit operations take two cycles, the rest one
			if (w_data_reg[4:0] == `BFU_OP_POP || w_data_reg[4:0] == `BFU_OP_IO_SET ||
				w_data_reg[4:0] == `BFU_OP_IO_CLR) begin
				cnt_reg <= `BFU_CYC_TWO;
			end else begin
				cnt_reg <= `BFU_CYC_ONE;
			end
		end else if (finish) begin
			busy    <= 1'b0;
			cnt_reg <= 2'd0;
		end else if (busy) begin
			cnt_reg <= cnt_reg - 2'd1;
		end
	end

	// Datapath: bus writes first, then the finishing command overrides them
	always @(posedge clk_sys) begin
		if (!nrst) begin
			for (i = 0; i < WREG_NUM; i = i + 1) begin
				wreg_reg[i] <= `BFU_DATA_RST;
			end
			for (i = 0; i < IO_NUM; i = i + 1) begin
				io_reg[i] <= `BFU_DATA_RST;
			end
			flags_reg           <= `BFU_FLAGS_RST;
			stack_top_reg       <= `BFU_DATA_RST;
			flags_out           <= `BFU_FLAGS_RST;
			sleep_req           <= 1'b0;
			watchdog_restart_op <= 1'b0;
		end else begin
			// Only byte lane 0 carries register data
			if (do_wr && strb0 && wr_ok) begin
				if (aw_addr_reg == `BFU_OFS_FLAGS) begin
					flags_reg <= wbyte;
				end else if (aw_addr_reg == `BFU_OFS_STACK_TOP) begin
					stack_top_reg <= wbyte;
				end else if (aw_addr_reg[7:5] == `BFU_WREG_PAGE) begin
					wreg_reg[wa_idx] <= wbyte;
				end else if (aw_addr_reg[7:5] == `BFU_IO_PAGE) begin
					io_reg[wa_idx] <= wbyte;
				end
			end
			sleep_req           <= finish && (op_reg == `BFU_OP_SLEEP);
			watchdog_restart_op <= finish && (op_reg == `BFU_OP_WD_RESTART);
			if (finish) begin
				case (op_reg)
					`BFU_OP_POP: begin
						wreg_reg[idx_reg] <= stack_top_reg;
					end
					`BFU_OP_IO_SET: begin
						io_reg[idx_reg][sel_reg] <= 1'b1;
					end
					`BFU_OP_IO_CLR: begin
						io_reg[idx_reg][sel_reg] <= 1'b0;
					end
					`BFU_OP_SLL, `BFU_OP_SRL, `BFU_OP_SRA, `BFU_OP_ROLC, `BFU_OP_RORC: begin
						// Z, C, N and V follow the result; V is N xor C
						wreg_reg[idx_reg]          <= res_next;
						flags_reg[`BFU_FLAG_C]     <= cout_next;
						flags_reg[`BFU_FLAG_Z]     <= (res_next == 8'h00);
						flags_reg[`BFU_FLAG_N]     <= res_next[7];
						flags_reg[`BFU_FLAG_V]     <= res_next[7] ^ cout_next;
					end
					`BFU_OP_SWAP: begin
						wreg_reg[idx_reg] <= res_next;
					end
					`BFU_OP_FSET: begin
						flags_reg[sel_reg] <= 1'b1;
					end
					`BFU_OP_FCLR: begin
						flags_reg[sel_reg] <= 1'b0;
					end
					`BFU_OP_TSTORE: begin
						flags_reg[`BFU_FLAG_T] <= wsel[sel_reg];
					end
					`BFU_OP_TLOAD: begin
						wreg_reg[idx_reg][sel_reg] <= flags_reg[`BFU_FLAG_T];
					end
					`BFU_OP_VSET: begin
						flags_reg[`BFU_FLAG_V] <= 1'b1;
					end
					`BFU_OP_VCLR: begin
						flags_reg[`BFU_FLAG_V] <= 1'b0;
					end
					`BFU_OP_HSET: begin
						flags_reg[`BFU_FLAG_H] <= 1'b1;
					end
					`BFU_OP_HCLR: begin
						flags_reg[`BFU_FLAG_H] <= 1'b0;
					end
					`BFU_OP_SSET: begin
						flags_reg[`BFU_FLAG_S] <= 1'b1;
					end
					`BFU_OP_SCLR: begin
						flags_reg[`BFU_FLAG_S] <= 1'b0;
					end
					default: begin
						// No operation, sleep and watchdog restart touch no state here
					end
				endcase
			end
			// Mirror one cycle late; a trade for a clean flop-driven output
			flags_out <= flags_reg;
		end
	end

endmodule // bfu_top

// *** testbench/bfu_top_props.sv ***
/* Checker for bfu_top: handshake holding, busy length, flag effects.
   Assumes one clock and command words taken with aw and w together. */
`timescale 1ns/100ps
`include "bfu_defines.vh"
module bfu_top_props (
	input wire        clk_sys,
	input wire        nrst,
	input wire [31:0] s_axi_wdata,
	input wire [3:0]  s_axi_wstrb,
	input wire        s_axi_wvalid,
	input wire        s_axi_wready,
	input wire        s_axi_awready,
	input wire [1:0]  s_axi_bresp,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire [31:0] s_axi_rdata,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire        busy,
	input wire [7:0]  flags_out,
	input wire        sleep_req
);
	reg  [4:0] op_reg;	// Opcode of the last word taken
	reg  [2:0] sel_reg;	// Bit select of that word
	wire       two  = op_reg == `BFU_OP_POP || op_reg == `BFU_OP_IO_SET ||
		op_reg == `BFU_OP_IO_CLR;
	wire       vop  = op_reg == `BFU_OP_VSET || op_reg == `BFU_OP_VCLR;
	wire       hsop = op_reg >= `BFU_OP_HSET && op_reg <= `BFU_OP_SCLR;
	wire       gop  = op_reg == `BFU_OP_FSET || op_reg == `BFU_OP_FCLR;
	wire       keep = two || op_reg == `BFU_OP_NOP || op_reg == `BFU_OP_SWAP ||
		op_reg == `BFU_OP_TLOAD || op_reg == `BFU_OP_SLEEP;
	// Data words other than commands pass here too; only busy tells them apart
	always @(posedge clk_sys) begin
		if (!nrst) begin
			op_reg  <= 5'h00;
			sel_reg <= 3'h0;
		end else if (s_axi_wvalid && s_axi_wready && s_axi_wstrb[0]) begin
			op_reg  <= s_axi_wdata[4:0];
			sel_reg <= s_axi_wdata[10:8];
		end
	end
	reg  [7:0] f_start;	// Flags seen as the command started
	reg        busy_d;	// busy one edge ago
	// Base for flag checks; kept in helper logic so no property variable is needed
	always @(posedge clk_sys) begin
		if (!nrst) begin
			busy_d  <= 1'b0;
			f_start <= 8'h00;
		end else begin
			busy_d <= busy;
			if (busy && !busy_d) begin
				f_start <= flags_out;
			end
		end
	end
	// Flags expected after a flag set or clear command
	function [7:0] fexp(input [7:0] f);
		begin
			fexp = f;
			case (op_reg)
				`BFU_OP_FSET: fexp[sel_reg] = 1'b1;
				`BFU_OP_FCLR: fexp[sel_reg] = 1'b0;
				`BFU_OP_VSET: fexp[`BFU_FLAG_V] = 1'b1;
				`BFU_OP_VCLR: fexp[`BFU_FLAG_V] = 1'b0;
				`BFU_OP_HSET: fexp[`BFU_FLAG_H] = 1'b1;
				`BFU_OP_HCLR: fexp[`BFU_FLAG_H] = 1'b0;
				`BFU_OP_SSET: fexp[`BFU_FLAG_S] = 1'b1;
				default: fexp[`BFU_FLAG_S] = 1'b0;
			endcase
		end
	endfunction
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	sequence two_s;
		busy ##1 !busy;
	endsequence
	// flags_out trails the flags register by one cycle, hence the late window
	property flag_p(g);
		$rose(busy) && g |-> ##[1:3] flags_out == fexp(f_start);
	endproperty
	property keep_p;
		$rose(busy) && keep |=> (flags_out == f_start) [*3];
	endproperty
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
	awready_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("awready too long");
	busy_start_a: assert property ($rose(busy) |-> $rose(s_axi_bvalid))
		else $error("busy without response");
	busy_one_a: assert property ($rose(busy) && !two |=> !busy)
		else $error("one-cycle op too long");
	busy_two_a: assert property ($rose(busy) && two |=> two_s)
		else $error("two-cycle op wrong length");
	overflow_flag_a: assert property (flag_p(vop))
		else $error("overflow command wrong");
	hcarry_signed_a: assert property (flag_p(hsop))
		else $error("half-carry or signed command wrong");
	flag_generic_a: assert property (flag_p(gop))
		else $error("generic flag command wrong");
	flags_kept_a: assert property (keep_p)
		else $error("flags disturbed");
	sleep_pulse_a: assert property (sleep_req |=> !sleep_req)
		else $error("sleep pulse too long");
endmodule // bfu_top_props
bind bfu_top bfu_top_props u_bfu_top_props (.clk_sys(clk_sys), .nrst(nrst),
	.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .busy(busy),
	.flags_out(flags_out), .sleep_req(sleep_req));

// *** testbench/bfu_top_bench.sv ***
/* Bench for bfu_top: every opcode runs through the register slave and
   read-back is compared with a bench model. Assumes the unit's register map. */
`timescale 1ns/100ps
`include "bfu_defines.vh"
module bfu_top_bench;
	reg         clk_sys = 1'b0;	// 100 MHz
	reg         nrst = 1'b0;	// Held low five cycles
	reg  [7:0]  awaddr = 8'h00;
	reg  [7:0]  araddr = 8'h00;
	reg  [31:0] wdata = 32'h0;
	reg  [3:0]  wstrb = 4'hf;
	reg         awvalid = 1'b0;
	reg         wvalid = 1'b0;
	reg         bready = 1'b0;
	reg         arvalid = 1'b0;
	reg         rready = 1'b0;
	wire        awready, wready, bvalid, arready, rvalid, busy, sleep_req, restart;
	wire [1:0]  bresp, rresp;
	wire [31:0] rdata;
	wire [7:0]  flags_out;
	reg  [33:0] rq[$];	// Expected {rresp, rdata}
	reg  [1:0]  bq[$];	// Expected bresp
	reg  [31:0] seed = 32'he573e7b0;
	integer     num_errors = 0, n_tests = 0, cyc = 0, i, j;
	integer     n_sleep = 0, n_rst = 0, e_sleep = 0, e_rst = 0;
	always #5 clk_sys = ~clk_sys;
	bfu_top u_bfu_top (.clk_sys(clk_sys), .nrst(nrst), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .busy(busy), .flags_out(flags_out),
		.sleep_req(sleep_req), .watchdog_restart_op(restart));
	function [31:0] lfsr_next(input [31:0] x);
		lfsr_next = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	// Returns {flags, register} after one command
	function [15:0] model(input [4:0] op, input [2:0] s, input [7:0] r, input [7:0] f);
		reg [7:0] q, g;
		reg       c;
		begin
			q = r;
			g = f;
			c = f[`BFU_FLAG_C];
			case (op)
				`BFU_OP_SLL: {c, q} = {r, 1'b0};
				`BFU_OP_SRL: {q, c} = {1'b0, r};
				`BFU_OP_ROLC: {c, q} = {r, f[`BFU_FLAG_C]};
				`BFU_OP_RORC: {q, c} = {f[`BFU_FLAG_C], r};
				`BFU_OP_SRA: {q, c} = {r[7], r};
				`BFU_OP_SWAP: q = {r[3:0], r[7:4]};
				`BFU_OP_IO_SET: q[s] = 1'b1;
				`BFU_OP_IO_CLR: q[s] = 1'b0;
				`BFU_OP_FSET: g[s] = 1'b1;
				`BFU_OP_FCLR: g[s] = 1'b0;
				`BFU_OP_TSTORE: g[`BFU_FLAG_T] = r[s];
				`BFU_OP_TLOAD: q[s] = f[`BFU_FLAG_T];
				`BFU_OP_VSET: g[`BFU_FLAG_V] = 1'b1;
				`BFU_OP_VCLR: g[`BFU_FLAG_V] = 1'b0;
				`BFU_OP_HSET: g[`BFU_FLAG_H] = 1'b1;
				`BFU_OP_HCLR: g[`BFU_FLAG_H] = 1'b0;
				`BFU_OP_SSET: g[`BFU_FLAG_S] = 1'b1;
				`BFU_OP_SCLR: g[`BFU_FLAG_S] = 1'b0;
				default: q = r;
			endcase
			// Shifts and rotates recompute Z, C, N and V; S and H stay
			if (op >= `BFU_OP_SLL && op <= `BFU_OP_SRA) begin
				g[`BFU_FLAG_C] = c;
				g[`BFU_FLAG_Z] = (q == 8'h00);
				g[`BFU_FLAG_N] = q[7];
				g[`BFU_FLAG_V] = q[7] ^ c;
			end
			model = {g, q};
		end
	endfunction
	task check(input [63:0] nm, input [33:0] e, input [33:0] s);
		begin
			n_tests = n_tests + 1;
			if (s !== e) begin
				num_errors = num_errors + 1;
				$display("BAD %0s expected %h seen %h", nm, e, s);
			end
		end
	endtask
	// Offers address and data together, releases each when taken
	task wr(input [7:0] a, input [31:0] d, input [1:0] er);
		reg ad, wd;
		begin
			bq.push_back(er);
			ad = 1'b0;
			wd = 1'b0;
			@(posedge clk_sys);
			awaddr <= a;
			wdata <= d;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
			while (!(ad && wd)) begin
				@(posedge clk_sys);
				if (awready === 1'b1 && !ad) begin
					awvalid <= 1'b0;
					ad = 1'b1;
				end
				if (wready === 1'b1 && !wd) begin
					wvalid <= 1'b0;
					wd = 1'b1;
				end
			end
			while (bvalid !== 1'b1) @(posedge clk_sys);
			bready <= 1'b0;
		end
	endtask
	task rd(input [7:0] a, input [33:0] e);
		begin
			rq.push_back(e);
			@(posedge clk_sys);
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
			while (arready !== 1'b1) @(posedge clk_sys);
			arvalid <= 1'b0;
			while (rvalid !== 1'b1) @(posedge clk_sys);
			rready <= 1'b0;
		end
	endtask
	// Loads operands, issues one command, reads target and flags back
	task run_op(input [4:0] op, input [2:0] s);
		reg [7:0]  r, f, a;
		reg [2:0]  ix;
		reg [15:0] e;
		begin
			seed = lfsr_next(seed);
			r = seed[7:0];
			f = seed[15:8];
			ix = seed[18:16];
			e = model(op, s, r, f);
			a = (op == `BFU_OP_IO_SET || op == `BFU_OP_IO_CLR) ?
				`BFU_OFS_IO_BASE : `BFU_OFS_WREG_BASE;
			a = a + {3'h0, ix, 2'h0};
			wr(a, {24'h0, (op == `BFU_OP_POP) ? ~r : r}, `BFU_RESP_OKAY);
			wr(`BFU_OFS_STACK_TOP, {24'h0, r}, `BFU_RESP_OKAY);
			wr(`BFU_OFS_FLAGS, {24'h0, f}, `BFU_RESP_OKAY);
			wr(`BFU_OFS_CMD, {13'h0, ix, 5'h0, s, 3'h0, op}, `BFU_RESP_OKAY);
			while (busy !== 1'b0) @(posedge clk_sys);
			rd(a, {26'h0, e[7:0]});
			rd(`BFU_OFS_FLAGS, {26'h0, e[15:8]});
			e_sleep = e_sleep + (op == `BFU_OP_SLEEP);
			e_rst = e_rst + (op == `BFU_OP_WD_RESTART);
		end
	endtask
	task complete_run;
		begin
			if (num_errors == 0 && n_tests > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask
	// Output watcher: pairs each answer with the oldest expectation
	always @(posedge clk_sys) begin
		if (rvalid === 1'b1 && rready) check("read", rq.pop_front(), {rresp, rdata});
		if (bvalid === 1'b1 && bready) check("wresp", {32'h0, bq.pop_front()}, {32'h0, bresp});
		n_sleep = n_sleep + (sleep_req === 1'b1);
		n_rst = n_rst + (restart === 1'b1);
	end
	// Hang guard, well above the few thousand cycles the run needs
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			num_errors = num_errors + 1;
			complete_run;
		end
	end
	initial begin
		repeat (5) @(posedge clk_sys);
		nrst <= 1'b1;
		rd(`BFU_OFS_FLAGS, 34'h0);
		rd(`BFU_OFS_STATUS, 34'h0);
		rd(8'h20, {`BFU_RESP_SLVERR, 32'h0});
		rd(8'h41, {`BFU_RESP_SLVERR, 32'h0});
		wr(8'h24, 32'h5, `BFU_RESP_SLVERR);
		wstrb <= 4'h0;
		wr(`BFU_OFS_FLAGS, 32'hff, `BFU_RESP_OKAY);
		wstrb <= 4'hf;
		rd(`BFU_OFS_FLAGS, 34'h0);
		// Every opcode twice, with fresh random operands each time
		for (j = 0; j < 2; j = j + 1) begin
			run_op(`BFU_OP_NOP, seed[26:24]);
			run_op(`BFU_OP_POP, seed[26:24]);
			run_op(`BFU_OP_IO_SET, seed[26:24]);
			run_op(`BFU_OP_IO_CLR, seed[26:24]);
			run_op(`BFU_OP_SLL, seed[26:24]);
			run_op(`BFU_OP_SRL, seed[26:24]);
			run_op(`BFU_OP_ROLC, seed[26:24]);
			run_op(`BFU_OP_RORC, seed[26:24]);
			run_op(`BFU_OP_SRA, seed[26:24]);
			run_op(`BFU_OP_SWAP, seed[26:24]);
			run_op(`BFU_OP_FSET, seed[26:24]);
			run_op(`BFU_OP_FCLR, seed[26:24]);
			run_op(`BFU_OP_TSTORE, seed[26:24]);
			run_op(`BFU_OP_TLOAD, seed[26:24]);
			run_op(`BFU_OP_VSET, seed[26:24]);
			run_op(`BFU_OP_VCLR, seed[26:24]);
			run_op(`BFU_OP_HSET, seed[26:24]);
			run_op(`BFU_OP_HCLR, seed[26:24]);
			run_op(`BFU_OP_SSET, seed[26:24]);
			run_op(`BFU_OP_SCLR, seed[26:24]);
			run_op(`BFU_OP_SLEEP, seed[26:24]);
			run_op(`BFU_OP_WD_RESTART, seed[26:24]);
		end
		for (i = 0; i < 8; i = i + 1) begin
			run_op(`BFU_OP_FSET, i[2:0]);
			run_op(`BFU_OP_FCLR, i[2:0]);
		end
		check("sleep", {2'b0, e_sleep}, {2'b0, n_sleep});
		check("restart", {2'b0, e_rst}, {2'b0, n_rst});
		complete_run;
	end
endmodule // bfu_top_bench
